//--- shared/flash_nv_pkg.sv
package flash_nv_pkg;

  // ----------------------------------------------------------------------
  // Flash geometry and lock regions
  // ----------------------------------------------------------------------
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_W = 11;
  localparam int PAGES_PER_REGION = 64;
  localparam int REGION_SHIFT = $clog2(PAGES_PER_REGION);
  localparam int MAX_LOCKS = 32;
  localparam int LOCK_IDX_W = 5;
  localparam int MAX_PLANES = 2;

  // ----------------------------------------------------------------------
  // General-purpose and calibration bits
  // ----------------------------------------------------------------------
  localparam int GP_BITS = 3;
  localparam int GP_BOD_EN = 0;
  localparam int GP_BOD_RST = 1;
  localparam int GP_BOOT_FLASH = 2;
  localparam int GP_IDX_W = 2;
  localparam int CAL_BITS = 8;

  // ----------------------------------------------------------------------
  // Layout of the nonvolatile image
  // ----------------------------------------------------------------------
  localparam int NV_LOCK_LSB = 0;
  localparam int NV_SEC_POS = 32;
  localparam int NV_GP_LSB = 33;
  localparam int NV_W = 36;

  // ----------------------------------------------------------------------
  // Command codes shared by the user interfaces and the fast port
  // ----------------------------------------------------------------------
  localparam int CMD_W = 4;
  localparam logic [CMD_W-1:0] CMD_READ = 4'h0;
  localparam logic [CMD_W-1:0] CMD_PROG_PAGE = 4'h1;
  localparam logic [CMD_W-1:0] CMD_ERASE_PAGE = 4'h2;
  localparam logic [CMD_W-1:0] CMD_FULL_ERASE = 4'h3;
  localparam logic [CMD_W-1:0] CMD_SET_LOCK = 4'h4;
  localparam logic [CMD_W-1:0] CMD_CLR_LOCK = 4'h5;
  localparam logic [CMD_W-1:0] CMD_SET_GP = 4'h6;
  localparam logic [CMD_W-1:0] CMD_CLR_GP = 4'h7;
  localparam logic [CMD_W-1:0] CMD_SET_SEC = 4'h8;

  // ----------------------------------------------------------------------
  // Operations handed to a flash plane
  // ----------------------------------------------------------------------
  localparam int FOP_W = 2;
  localparam logic [FOP_W-1:0] FOP_PROG = 2'h0;
  localparam logic [FOP_W-1:0] FOP_ERASE = 2'h1;
  localparam logic [FOP_W-1:0] FOP_FULL = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [MAX_LOCKS-1:0] LOCK_RST = 32'h0;
  localparam logic [GP_BITS-1:0] GP_RST = 3'h0;
  localparam logic SEC_RST = 1'b0;
  localparam logic [CAL_BITS-1:0] CAL_RST = 8'h00;

endpackage : flash_nv_pkg

//--- src/pin_sync.sv
module pin_sync
  import flash_nv_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous pins and their synchronised copies.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // Two flip-flops per pin; only the second stage is read outside.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pin_sync

//--- src/cmd_decode.sv
module cmd_decode
  import flash_nv_pkg::*;
#(
  parameter int NUM_PLANES = 2,
  parameter int LOCKS_PER_PLANE = 16,
  parameter bit FAST_PORT = 1'b0,
  parameter int OWN_PLANE = 0
) (
  // Command from one source.
  input wire logic valid,
  input wire logic [CMD_W-1:0] code,
  input wire logic [PAGE_W-1:0] page,
  // Present state of the protection bits and the planes.
  input wire logic allowed,
  input wire logic [MAX_LOCKS-1:0] locks,
  input wire logic [NUM_PLANES-1:0] plane_busy,
  // Decoded effects of the command.
  output logic [MAX_LOCKS-1:0] lock_set,
  output logic [MAX_LOCKS-1:0] lock_clr,
  output logic [GP_BITS-1:0] gp_set,
  output logic [GP_BITS-1:0] gp_clr,
  output logic sec_set,
  output logic [NUM_PLANES-1:0] start,
  output logic [FOP_W-1:0] op,
  // Outcome of the command.
  output logic done,
  output logic read_ok,
  output logic lock_err,
  output logic refused
);

  localparam int NLOCK = NUM_PLANES * LOCKS_PER_PLANE;

  // One-hot plane vector for a plane number.
  function automatic logic [NUM_PLANES-1:0] plane_bit(input int n);
    logic [NUM_PLANES-1:0] v;
    v = '0;
    for (int p = 0; p < NUM_PLANES; p++) begin
      if (p == n) begin
        v[p] = 1'b1;
      end
    end
    return v;
  endfunction : plane_bit

  // Lock bits that cover the given planes.
  function automatic logic [MAX_LOCKS-1:0] region_mask(
    input logic [NUM_PLANES-1:0] pl
  );
    logic [MAX_LOCKS-1:0] m;
    m = '0;
    for (int i = 0; i < NLOCK; i++) begin
      if (pl[i / LOCKS_PER_PLANE]) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : region_mask

  // ----------------------------------------------------------------------
  // Target region and plane
  // ----------------------------------------------------------------------
  wire [LOCK_IDX_W-1:0] idx = page[REGION_SHIFT +: LOCK_IDX_W];
  wire [GP_IDX_W-1:0] gp_idx = page[GP_IDX_W-1:0];
  wire in_range = int'(idx) < NLOCK;
  wire [NUM_PLANES-1:0] page_plane = plane_bit(int'(idx) / LOCKS_PER_PLANE);
  wire [NUM_PLANES-1:0] own_plane = plane_bit(OWN_PLANE);

  // ----------------------------------------------------------------------
  // Command class
  // ----------------------------------------------------------------------
  wire is_read = FAST_PORT && (code == CMD_READ);
  wire is_prog = code == CMD_PROG_PAGE;
  wire is_erase = code == CMD_ERASE_PAGE;
  wire is_full = code == CMD_FULL_ERASE;
  wire is_slock = code == CMD_SET_LOCK;
  wire is_clock = code == CMD_CLR_LOCK;
  wire is_sgp = !FAST_PORT && (code == CMD_SET_GP);
  wire is_cgp = !FAST_PORT && (code == CMD_CLR_GP);
  wire is_sec = code == CMD_SET_SEC;
  wire is_page_op = is_prog || is_erase;
  wire is_page = is_page_op || is_read || is_slock || is_clock;
  wire known = is_page || is_full || is_sgp || is_cgp || is_sec;

  // A controller runs page and full erase only in its own plane.
  wire [NUM_PLANES-1:0] full_tgt = FAST_PORT ? '1 : own_plane;
  wire [NUM_PLANES-1:0] tgt = is_full ? full_tgt : page_plane;
  wire own_ok = FAST_PORT || !is_page_op || (page_plane == own_plane);
  wire uses_plane = is_page_op || is_full || is_read;
  wire busy_hit = uses_plane && |(tgt & plane_busy);
  wire gp_ok = !(is_sgp || is_cgp) || (int'(gp_idx) < GP_BITS);

  // ----------------------------------------------------------------------
  // Outcome
  // ----------------------------------------------------------------------
  wire bad = !allowed || !known || (is_page && !in_range) || !own_ok ||
             !gp_ok || busy_hit;
  wire locked = is_page_op ? locks[idx] :
                (is_full && |(locks & region_mask(tgt)));
  wire ok = valid && !bad && !locked;
  wire [MAX_LOCKS-1:0] one_lock = {{(MAX_LOCKS-1){1'b0}}, 1'b1} << idx;
  wire [GP_BITS-1:0] one_gp = {{(GP_BITS-1){1'b0}}, 1'b1} << gp_idx;

  // Effects are only produced by an accepted command.
  assign refused = valid && bad;
  assign lock_err = valid && !bad && locked;
  assign done = ok;
  assign read_ok = ok && is_read;
  assign lock_set = (ok && is_slock) ? one_lock : '0;
  assign lock_clr = (ok && is_clock) ? one_lock : '0;
  assign gp_set = (ok && is_sgp) ? one_gp : '0;
  assign gp_clr = (ok && is_cgp) ? one_gp : '0;
  assign sec_set = ok && is_sec;
  assign start = (ok && (is_page_op || is_full)) ? tgt : '0;
  assign op = is_full ? FOP_FULL : (is_erase ? FOP_ERASE : FOP_PROG);

endmodule : cmd_decode

//--- src/flash_nv_bit_protection.sv
// Contract
// - Dual plane: two controllers, 16 lock bits each, 32 regions of 64 pages.
// - Single plane 256K: one controller with 16 lock bits of 64 pages.
// - Single plane 128K: one controller with 8 lock bits of 64 pages.
// - Program or erase on a locked region aborts and raises an interrupt.
// - Set-lock protects the addressed region; clear-lock unprotects it.
// - Erase pin clears every lock bit.
// - Dual plane: every lock bit is reachable from either controller.
// - Reads of one plane proceed while the other plane is busy.
// - Security bit set refuses debug port and fast port flash access.
// - Only set-security sets it; erase pin plus full erase clears it.
// - General bit 0 enables the brownout detector; erase pin clears it.
// - General bit 1 enables brownout reset; erase pin clears it.
// - General bits are set and cleared by their own commands.
// - Eight factory calibration bits are unwritable and survive the erase pin.
// - Fast programming needs the test pin and port A lines 0 and 1 high.
// - Fast port takes read, program, erase, full erase, lock, unlock, protect.
// - General bit 2 set boots from flash; clear maps the boot ROM at zero.
// - Erase pin clears general bit 2, returning to boot from ROM.
module flash_nv_bit_protection
  import flash_nv_pkg::*;
#(
  parameter int NUM_PLANES = 2,
  parameter int LOCKS_PER_PLANE = 16
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Device pins.
  input wire logic ERASE_PIN,
  input wire logic TEST_MODE_PIN,
  input wire logic PORT_A_LINE_ZERO,
  input wire logic PORT_A_LINE_ONE,
  // User interface commands, one slice per controller.
  input wire logic [NUM_PLANES-1:0] CMD_VALID,
  input wire logic [NUM_PLANES*CMD_W-1:0] CMD_CODE,
  input wire logic [NUM_PLANES*PAGE_W-1:0] CMD_PAGE,
  output logic [NUM_PLANES-1:0] CMD_DONE,
  output logic [NUM_PLANES-1:0] CMD_REFUSED,
  output logic [NUM_PLANES-1:0] CMD_LOCK_IRQ,
  // Fast programming port commands.
  input wire logic FP_CMD_VALID,
  input wire logic [CMD_W-1:0] FP_CMD_CODE,
  input wire logic [PAGE_W-1:0] FP_CMD_PAGE,
  output logic FP_MODE,
  output logic FP_DONE,
  output logic FP_REFUSED,
  output logic FP_LOCK_ERR,
  output logic FP_READ_GRANT,
  // Debug emulator port access check.
  input wire logic DBG_REQ,
  output logic DBG_GRANT,
  // Flash plane sequencers.
  input wire logic [NUM_PLANES-1:0] FLASH_BUSY,
  output logic [NUM_PLANES-1:0] FLASH_START,
  output logic [NUM_PLANES*FOP_W-1:0] FLASH_OP,
  output logic [NUM_PLANES*PAGE_W-1:0] FLASH_PAGE,
  output logic [NUM_PLANES-1:0] PLANE_READ_OK,
  // Nonvolatile bit storage.
  input wire logic [NV_W-1:0] NV_IMAGE_IN,
  input wire logic [CAL_BITS-1:0] CAL_IN,
  output logic NV_WRITE,
  output logic [NV_W-1:0] NV_IMAGE_OUT,
  // Protection and configuration status.
  output logic RESTORE_DONE,
  output logic [MAX_LOCKS-1:0] LOCK_BITS,
  output logic SECURITY,
  output logic BOD_ENABLE,
  output logic BOD_RESET_ENABLE,
  output logic BOOT_FROM_FLASH,
  output logic [CAL_BITS-1:0] CAL_BITS_OUT
);

  localparam int NP = NUM_PLANES;
  localparam int NS = NUM_PLANES + 1;
  localparam int NLOCK = NUM_PLANES * LOCKS_PER_PLANE;
  localparam logic [MAX_LOCKS-1:0] LOCK_MASK =
    MAX_LOCKS'((64'(1) << NLOCK) - 64'(1));

  typedef enum logic [1:0] {
    S_RESTORE,
    S_RUN,
    S_WIPE_START,
    S_WIPE_WAIT
  } seq_e;

  seq_e state, next_state;
  logic [MAX_LOCKS-1:0] locks, next_locks;
  logic [GP_BITS-1:0] gp, next_gp;
  logic sec, next_sec;
  logic armed;
  logic [CAL_BITS-1:0] cal;
  logic [NP-1:0][FOP_W-1:0] flash_op, next_op;
  logic [NP-1:0][PAGE_W-1:0] flash_page, next_page;
  logic [NP-1:0] next_start;
  logic [NV_W-1:0] nv_image;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pins_s;

  pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .d({ERASE_PIN, TEST_MODE_PIN, PORT_A_LINE_ZERO, PORT_A_LINE_ONE}),
    .q(pins_s)
  );

  // The erase pin acts on its level; a held pin wipes only once.
  wire erase_s = pins_s[3];
  wire fp_entry = &pins_s[2:0];
  wire run = (state == S_RUN) && !erase_s;
  wire allow_ctrl = run && !FP_MODE;
  wire allow_fp = run && FP_MODE && !sec;
  wire [NP-1:0] plane_busy = FLASH_BUSY | FLASH_START;

  // ----------------------------------------------------------------------
  // Command decoders: one per controller, the last for the fast port
  // ----------------------------------------------------------------------
  logic src_valid [NS];
  logic [CMD_W-1:0] src_code [NS];
  logic [PAGE_W-1:0] src_page [NS];
  logic src_allow [NS];
  logic [MAX_LOCKS-1:0] d_lset [NS];
  logic [MAX_LOCKS-1:0] d_lclr [NS];
  logic [GP_BITS-1:0] d_gset [NS];
  logic [GP_BITS-1:0] d_gclr [NS];
  logic [NP-1:0] d_start [NS];
  logic [FOP_W-1:0] d_op [NS];
  logic [NS-1:0] d_sec, d_done, d_read, d_lerr, d_ref;

  for (genvar s = 0; s < NS; s++) begin : g_src
    if (s < NP) begin : g_ctrl
      // Every controller sees the full lock vector of the device.
      assign src_valid[s] = CMD_VALID[s];
      assign src_code[s] = CMD_CODE[s*CMD_W +: CMD_W];
      assign src_page[s] = CMD_PAGE[s*PAGE_W +: PAGE_W];
      assign src_allow[s] = allow_ctrl;
    end else begin : g_fast
      assign src_valid[s] = FP_CMD_VALID;
      assign src_code[s] = FP_CMD_CODE;
      assign src_page[s] = FP_CMD_PAGE;
      assign src_allow[s] = allow_fp;
    end

    cmd_decode #(
      .NUM_PLANES(NP),
      .LOCKS_PER_PLANE(LOCKS_PER_PLANE),
      .FAST_PORT(s == NP),
      .OWN_PLANE((s < NP) ? s : 0)
    ) u_dec (
      .valid(src_valid[s]),
      .code(src_code[s]),
      .page(src_page[s]),
      .allowed(src_allow[s]),
      .locks(locks),
      .plane_busy(plane_busy),
      .lock_set(d_lset[s]),
      .lock_clr(d_lclr[s]),
      .gp_set(d_gset[s]),
      .gp_clr(d_gclr[s]),
      .sec_set(d_sec[s]),
      .start(d_start[s]),
      .op(d_op[s]),
      .done(d_done[s]),
      .read_ok(d_read[s]),
      .lock_err(d_lerr[s]),
      .refused(d_ref[s])
    );
  end

  // ----------------------------------------------------------------------
  // Merge of all sources; a set wins over a clear of the same bit
  // ----------------------------------------------------------------------
  logic [MAX_LOCKS-1:0] all_lset, all_lclr;
  logic [GP_BITS-1:0] all_gset, all_gclr;
  logic [NP-1:0] cmd_start;
  logic [NP-1:0][FOP_W-1:0] cmd_op;
  logic [NP-1:0][PAGE_W-1:0] cmd_page;

  always_comb begin
    all_lset = '0;
    all_lclr = '0;
    all_gset = '0;
    all_gclr = '0;
    cmd_start = '0;
    cmd_op = flash_op;
    cmd_page = flash_page;
    for (int s = 0; s < NS; s++) begin
      all_lset = all_lset | d_lset[s];
      all_lclr = all_lclr | d_lclr[s];
      all_gset = all_gset | d_gset[s];
      all_gclr = all_gclr | d_gclr[s];
      for (int p = 0; p < NP; p++) begin
        if (d_start[s][p]) begin
          cmd_start[p] = 1'b1;
          cmd_op[p] = d_op[s];
          cmd_page[p] = src_page[s];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: restore, normal service and erase-pin wipe
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_locks = locks;
    next_gp = gp;
    next_sec = sec;
    next_start = '0;
    next_op = flash_op;
    next_page = flash_page;
    unique case (state)
      S_RESTORE: begin
        next_locks = NV_IMAGE_IN[NV_LOCK_LSB +: MAX_LOCKS] & LOCK_MASK;
        next_gp = NV_IMAGE_IN[NV_GP_LSB +: GP_BITS];
        next_sec = NV_IMAGE_IN[NV_SEC_POS];
        next_state = S_RUN;
      end
      S_RUN: begin
        if (erase_s && armed) begin
          next_locks = '0;
          next_gp[GP_BOD_EN] = 1'b0;
          next_gp[GP_BOD_RST] = 1'b0;
          next_gp[GP_BOOT_FLASH] = 1'b0;
          next_state = S_WIPE_START;
        end else begin
          next_locks = ((locks & ~all_lclr) | all_lset) & LOCK_MASK;
          next_gp = (gp & ~all_gclr) | all_gset;
          next_sec = sec | (|d_sec);
          next_start = cmd_start;
          next_op = cmd_op;
          next_page = cmd_page;
        end
      end
      S_WIPE_START: begin
        if (!(|plane_busy)) begin
          next_start = '1;
          for (int p = 0; p < NP; p++) begin
            next_op[p] = FOP_FULL;
            next_page[p] = '0;
          end
          next_state = S_WIPE_WAIT;
        end
      end
      S_WIPE_WAIT: begin
        if (!(|plane_busy)) begin
          next_sec = 1'b0;
          next_state = S_RUN;
        end
      end
    endcase
  end

  wire [NV_W-1:0] next_image = {next_gp, next_sec, next_locks};

  // State and protection bits.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= S_RESTORE;
      locks <= LOCK_RST;
      gp <= GP_RST;
      sec <= SEC_RST;
    end else begin
      state <= next_state;
      locks <= next_locks;
      gp <= next_gp;
      sec <= next_sec;
    end
  end

  // Factory calibration is loaded once and has no write path.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cal <= CAL_RST;
    end else if (state == S_RESTORE) begin
      cal <= CAL_IN;
    end
  end

  // The wipe is re-armed only once the erase pin has been released.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      armed <= 1'b1;
    end else if (!erase_s) begin
      armed <= 1'b1;
    end else if (state == S_RUN) begin
      armed <= 1'b0;
    end
  end

  // Flash plane requests and per-plane read permission.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FLASH_START <= '0;
      flash_op <= '0;
      flash_page <= '0;
      PLANE_READ_OK <= '0;
    end else begin
      FLASH_START <= next_start;
      flash_op <= next_op;
      flash_page <= next_page;
      PLANE_READ_OK <= ~(FLASH_BUSY | next_start);
    end
  end

  // Command outcomes, one-cycle pulses.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_DONE <= '0;
      CMD_REFUSED <= '0;
      CMD_LOCK_IRQ <= '0;
      FP_DONE <= 1'b0;
      FP_REFUSED <= 1'b0;
      FP_LOCK_ERR <= 1'b0;
      FP_READ_GRANT <= 1'b0;
    end else begin
      CMD_DONE <= d_done[NP-1:0];
      CMD_REFUSED <= d_ref[NP-1:0];
      CMD_LOCK_IRQ <= d_lerr[NP-1:0];
      FP_DONE <= d_done[NP];
      FP_REFUSED <= d_ref[NP];
      FP_LOCK_ERR <= d_lerr[NP];
      FP_READ_GRANT <= d_read[NP];
    end
  end

  // Mode, debug gate and nonvolatile write-back.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FP_MODE <= 1'b0;
      DBG_GRANT <= 1'b0;
      NV_WRITE <= 1'b0;
      nv_image <= '0;
      RESTORE_DONE <= 1'b0;
    end else begin
      FP_MODE <= fp_entry;
      DBG_GRANT <= DBG_REQ && !next_sec;
      NV_WRITE <= (state != S_RESTORE) && (next_image != nv_image);
      nv_image <= next_image;
      RESTORE_DONE <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs, taken straight from the flip-flops
  // ----------------------------------------------------------------------
  assign FLASH_OP = flash_op;
  assign FLASH_PAGE = flash_page;
  assign NV_IMAGE_OUT = nv_image;
  assign LOCK_BITS = locks;
  assign SECURITY = sec;
  assign BOD_ENABLE = gp[GP_BOD_EN];
  assign BOD_RESET_ENABLE = gp[GP_BOD_RST];
  assign BOOT_FROM_FLASH = gp[GP_BOOT_FLASH];
  assign CAL_BITS_OUT = cal;

endmodule : flash_nv_bit_protection

//--- test/flash_plane_model.sv
module flash_plane_model
  import flash_nv_pkg::*;
#(
  parameter int NUM_PLANES = 2,
  parameter int BUSY_CYC = 6
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Start strobes in, busy levels out.
  input wire logic [NUM_PLANES-1:0] FLASH_START,
  output logic [NUM_PLANES-1:0] FLASH_BUSY
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt [NUM_PLANES];
  // Each plane is busy for a fixed count after its start strobe.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    for (int p = 0; p < NUM_PLANES; p++) begin
      if (!RESETN) cnt[p] <= 8'h00;
      else if (FLASH_START[p]) cnt[p] <= 8'(BUSY_CYC);
      else if (cnt[p] != 8'h00) cnt[p] <= cnt[p] - 8'h01;
    end
  end
  // Busy while the count runs.
  always_comb begin
    for (int p = 0; p < NUM_PLANES; p++) FLASH_BUSY[p] = cnt[p] != 8'h00;
  end
endmodule : flash_plane_model

//--- test/flash_nv_monitor.sv
module flash_nv_monitor
  import flash_nv_pkg::*;
#(
  parameter int NUM_PLANES = 2,
  parameter int LOCKS_PER_PLANE = 16
) (
  // Clock, reset and pins.
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic ERASE_PIN,
  input wire logic DBG_REQ,
  input wire logic DBG_GRANT,
  // Command answers.
  input wire logic [NUM_PLANES-1:0] CMD_VALID,
  input wire logic [NUM_PLANES-1:0] CMD_DONE,
  input wire logic [NUM_PLANES-1:0] CMD_REFUSED,
  input wire logic [NUM_PLANES-1:0] CMD_LOCK_IRQ,
  input wire logic FP_MODE,
  input wire logic FP_DONE,
  // Plane starts.
  input wire logic [NUM_PLANES-1:0] FLASH_START,
  input wire logic [NUM_PLANES*FOP_W-1:0] FLASH_OP,
  input wire logic [NUM_PLANES*PAGE_W-1:0] FLASH_PAGE,
  // Stored image and status.
  input wire logic NV_WRITE,
  input wire logic [NV_W-1:0] NV_IMAGE_OUT,
  input wire logic RESTORE_DONE,
  input wire logic [MAX_LOCKS-1:0] LOCK_BITS,
  input wire logic SECURITY,
  input wire logic BOD_ENABLE,
  input wire logic BOD_RESET_ENABLE,
  input wire logic BOOT_FROM_FLASH,
  input wire logic [CAL_BITS-1:0] CAL_BITS_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Erase pin held through the synchroniser, then the wiped state.
  sequence pin_held;
    ERASE_PIN [*5];
  endsequence
  sequence wiped;
    LOCK_BITS == '0 && !BOD_ENABLE && !BOD_RESET_ENABLE && !BOOT_FROM_FLASH;
  endsequence
  AST_ANSWER: assert property (
    CMD_VALID != '0 |=> (CMD_DONE | CMD_REFUSED | CMD_LOCK_IRQ)
    == $past(CMD_VALID)) else $error("command answer wrong");
  AST_LOCK_ABORT: assert property (
    (CMD_LOCK_IRQ & (CMD_DONE | CMD_REFUSED | FLASH_START)) == '0)
    else $error("locked abort also did something");
  AST_START_UNLOCKED: assert property (
    FLASH_START[0] && FLASH_OP[1:0] != FOP_FULL
    |-> !LOCK_BITS[FLASH_PAGE[PAGE_W-1:REGION_SHIFT]])
    else $error("start into a locked region");
  AST_WIPE: assert property (pin_held |-> wiped)
    else $error("erase pin left bits set");
  AST_CAL: assert property (
    RESTORE_DONE && $past(RESTORE_DONE) |-> $stable(CAL_BITS_OUT))
    else $error("calibration bits changed");
  AST_DBG: assert property (
    $past(RESETN) |-> DBG_GRANT == ($past(DBG_REQ) && !SECURITY))
    else $error("debug grant wrong");
  AST_FP_GATE: assert property (
    FP_DONE |-> $past(FP_MODE) && !$past(SECURITY))
    else $error("fast port accepted while barred");
  AST_NV_IMAGE: assert property (
    NV_WRITE |-> NV_IMAGE_OUT == {BOOT_FROM_FLASH, BOD_RESET_ENABLE,
    BOD_ENABLE, SECURITY, LOCK_BITS}) else $error("stored image wrong");
endmodule : flash_nv_monitor

bind flash_nv_bit_protection flash_nv_monitor #(
  .NUM_PLANES(NUM_PLANES), .LOCKS_PER_PLANE(LOCKS_PER_PLANE)
) flash_nv_monitor_inst (.*);

//--- test/flash_nv_bit_protection_tb_top.sv
module flash_nv_bit_protection_tb_top
  import flash_nv_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] dn = 3'b001, rf = 3'b010, ir = 3'b100;
  logic SYS_CLK, RESETN, ERASE_PIN, TEST_MODE_PIN, PORT_A_LINE_ZERO;
  logic PORT_A_LINE_ONE, FP_CMD_VALID, FP_MODE, FP_DONE, FP_REFUSED;
  logic FP_LOCK_ERR, FP_READ_GRANT, DBG_REQ, DBG_GRANT, NV_WRITE, gr;
  logic RESTORE_DONE, SECURITY, BOD_ENABLE, BOD_RESET_ENABLE;
  logic BOOT_FROM_FLASH;
  logic [1:0] CMD_VALID, CMD_DONE, CMD_REFUSED, CMD_LOCK_IRQ, st;
  logic [1:0] FLASH_BUSY, FLASH_START, PLANE_READ_OK;
  logic [7:0] CMD_CODE, CAL_IN, CAL_BITS_OUT;
  logic [21:0] CMD_PAGE, FLASH_PAGE;
  logic [3:0] FLASH_OP, FP_CMD_CODE;
  logic [10:0] FP_CMD_PAGE;
  logic [35:0] NV_IMAGE_IN, NV_IMAGE_OUT;
  logic [31:0] LOCK_BITS;
  logic [3:0] t_code [7] = '{CMD_SET_LOCK, CMD_PROG_PAGE, CMD_CLR_LOCK,
    CMD_PROG_PAGE, CMD_ERASE_PAGE, CMD_FULL_ERASE, CMD_SET_SEC};
  logic [10:0] t_page [7] = '{0, 2, 0, 2, 11'h402, 0, 0};
  logic [2:0] t_exp [7] = '{dn, ir, dn, dn, dn, dn, dn};
  int n_mismatch = 0;
  int total_checks = 0;

  // Design and plane partner.
  flash_nv_bit_protection #(.NUM_PLANES(2), .LOCKS_PER_PLANE(16))
    flash_nv_bit_protection_inst (.*);
  flash_plane_model #(.NUM_PLANES(2), .BUSY_CYC(6))
    flash_plane_model_inst (.*);

  // 50 MHz clock.
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  // --------------------------------------------------------------------
  // Checking and command tasks
  // --------------------------------------------------------------------
  function automatic logic [35:0] stat();
    return {BOOT_FROM_FLASH, BOD_RESET_ENABLE, BOD_ENABLE, SECURITY,
      LOCK_BITS};
  endfunction : stat

  task automatic chk(input string n, input logic [35:0] e,
    input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Source 2 is the fast port; the answer is read in the pulse cycle.
  task automatic cmd(input int c, input logic [3:0] code,
    input logic [10:0] pg, input logic [2:0] exp);
    logic [2:0] got;
    @(posedge SYS_CLK) #1;
    if (c == 2) {FP_CMD_VALID, FP_CMD_CODE, FP_CMD_PAGE} = {1'b1, code, pg};
    else begin
      CMD_VALID[c] = 1'b1;
      CMD_CODE[c*4+:4] = code;
      CMD_PAGE[c*11+:11] = pg;
    end
    @(posedge SYS_CLK) #1;
    got = (c == 2) ? {FP_LOCK_ERR, FP_REFUSED, FP_DONE}
      : {CMD_LOCK_IRQ[c], CMD_REFUSED[c], CMD_DONE[c]};
    st = FLASH_START;
    gr = FP_READ_GRANT;
    {FP_CMD_VALID, CMD_VALID} = 3'h0;
    chk("answer", 36'(exp), 36'(got));
  endtask : cmd

  // Bounded wait: planes idle (0) or security clear (1).
  task automatic wait_clear(input int sel);
    for (int i = 0; i < 100 && (sel ? SECURITY : |{FLASH_BUSY,
      FLASH_START}) !== 1'b0; i++) @(posedge SYS_CLK) #1;
    if ((sel ? SECURITY : |{FLASH_BUSY, FLASH_START}) !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask : wait_clear

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    RESETN = 1'b0;
    {ERASE_PIN, TEST_MODE_PIN, PORT_A_LINE_ZERO, PORT_A_LINE_ONE} = 4'h0;
    {DBG_REQ, FP_CMD_VALID, CMD_VALID, CMD_CODE, CMD_PAGE} = '0;
    {FP_CMD_CODE, FP_CMD_PAGE} = '0;
    NV_IMAGE_IN = 36'ha_0000_0004;
    CAL_IN = 8'h5a;
    repeat (16) @(posedge SYS_CLK);
    #1 RESETN = 1'b1;
    repeat (3) @(posedge SYS_CLK) #1;
    chk("restore", 36'ha_0000_0004, stat());
    chk("cal", 36'(8'h5a), 36'(CAL_BITS_OUT));
    cmd(0, CMD_SET_LOCK, 11'h040, dn);
    cmd(1, CMD_SET_LOCK, 11'h400, dn);
    cmd(0, CMD_SET_LOCK, 11'h7c0, dn);
    chk("locks", 36'h0_8001_0006, 36'(LOCK_BITS));
    cmd(0, CMD_ERASE_PAGE, 11'h045, ir);
    cmd(0, CMD_PROG_PAGE, 11'h0bf, ir);
    cmd(0, CMD_FULL_ERASE, 11'h000, ir);
    cmd(0, CMD_CLR_LOCK, 11'h07f, dn);
    cmd(0, CMD_PROG_PAGE, 11'h041, dn);
    chk("start", 36'h1, 36'(st));
    chk("read ok", 36'h2, 36'(PLANE_READ_OK));
    cmd(0, CMD_PROG_PAGE, 11'h005, rf);
    cmd(1, CMD_ERASE_PAGE, 11'h450, dn);
    wait_clear(0);
    cmd(1, CMD_PROG_PAGE, 11'h005, rf);
    for (int i = 0; i < 3; i++) cmd(0, CMD_SET_GP, 11'(i), dn);
    cmd(0, CMD_CLR_GP, 11'h000, dn);
    cmd(0, CMD_CLR_GP, 11'h003, rf);
    chk("gp", 36'h6, 36'(stat() >> 33));
    DBG_REQ = 1'b1;
    repeat (2) @(posedge SYS_CLK) #1;
    chk("dbg", 36'h1, 36'(DBG_GRANT));
    cmd(0, CMD_SET_SEC, 11'h000, dn);
    repeat (2) @(posedge SYS_CLK) #1;
    chk("dbg", 36'h2, 36'({SECURITY, DBG_GRANT}));
    {TEST_MODE_PIN, PORT_A_LINE_ZERO, PORT_A_LINE_ONE} = 3'h7;
    repeat (4) @(posedge SYS_CLK) #1;
    chk("fp mode", 36'h1, 36'(FP_MODE));
    cmd(0, CMD_SET_LOCK, 11'h000, rf);
    cmd(2, CMD_READ, 11'h000, rf);
    ERASE_PIN = 1'b1; // held over the wipe
    wait_clear(1);
    chk("wiped", 36'h0, stat());
    chk("cal", 36'(8'h5a), 36'(CAL_BITS_OUT));
    cmd(2, CMD_READ, 11'h000, rf);
    ERASE_PIN = 1'b0;
    repeat (4) @(posedge SYS_CLK) #1;
    cmd(2, CMD_READ, 11'h000, dn);
    chk("grant", 36'h1, 36'(gr));
    for (int i = 0; i < 7; i++) begin
      cmd(2, t_code[i], t_page[i], t_exp[i]);
      wait_clear(0);
    end
    end_sim();
  end
endmodule : flash_nv_bit_protection_tb_top
